/* rtl/acr_pkg.sv */
// Purpose: Types shared by the calibration register bank.
// Assumes: Constants live in acr_regs.svh.
// Notes:   Reference source codes follow the select fields.
package acr_pkg;
	typedef enum logic [1:0] {
		ACR_POS_INTERNAL = 2'h0,
		ACR_POS_SUPPLY   = 2'h1,
		ACR_POS_INPUT_0  = 2'h2,
		ACR_POS_INPUT_2  = 2'h3
	} acr_pos_src_t;
	typedef enum logic [1:0] {
		ACR_NEG_INTERNAL = 2'h0,
		ACR_NEG_SUPPLY   = 2'h1,
		ACR_NEG_INPUT_1  = 2'h2,
		ACR_NEG_INPUT_3  = 2'h3
	} acr_neg_src_t;
	typedef struct packed {
		logic         soft_sleep;
		logic         header_byte_on;
		logic         check_code_on;
		logic         serial_timeout_reset_on;
		logic         internal_vsrc_on;
		acr_pos_src_t pos_vsrc_select;
		acr_neg_src_t neg_vsrc_select;
	} acr_ctrl_t;
	typedef enum logic [1:0] {
		ACR_BUS_IDLE = 2'b01,
		ACR_BUS_ACK  = 2'b10
	} acr_bus_st_t;
endpackage

/* rtl/acr_regs.svh */
// Purpose: Offsets, field positions and reset values of the calibration register bank.
// Assumes: Word index times four is the Wishbone byte address.
// Notes:   Definitions only.
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH
`define ACR_IDX_W         6
`define ACR_IDX_PWR       6'h05
`define ACR_IDX_VSRC      6'h06
`define ACR_IDX_OFS_LO    6'h07
`define ACR_IDX_OFS_MID   6'h08
`define ACR_IDX_OFS_HI    6'h09
`define ACR_IDX_GAIN_LO   6'h0a
`define ACR_IDX_GAIN_MID  6'h0b
`define ACR_IDX_GAIN_HI   6'h0c
`define ACR_NUM_REGS      8
`define ACR_RST_PWR       8'h00
`define ACR_RST_VSRC      8'h05
`define ACR_RST_OFS       8'h00
`define ACR_RST_GAIN_LO   8'h00
`define ACR_RST_GAIN_MID  8'h00
`define ACR_RST_GAIN_HI   8'h40
`define ACR_BIT_SLEEP     7
`define ACR_BIT_HEADER    6
`define ACR_BIT_CHECK     5
`define ACR_BIT_TIMEOUT   4
`define ACR_PIN_MSB       3
`define ACR_BIT_VSRC_ON   4
`define ACR_POS_MSB       3
`define ACR_POS_LSB       2
`define ACR_NEG_MSB       1
`define ACR_NEG_LSB       0
`define ACR_GAIN_UNITY    24'h400000
`define ACR_GAIN_SHIFT    22
`define ACR_OUT_MAX       24'h7fffff
`define ACR_OUT_MIN       24'h800000
`endif

/* rtl/acr_top.sv */
// Purpose: Power, option, reference select and calibration registers with the
//          offset and gain correction of each conversion result.
// Assumes: Classic Wishbone slave, 32-bit data, byte lane 0 carries each register.
// Notes:   One clock, synchronous active high reset.
// Notes on behaviour
// (R1) Power bit 7 set means software sleep; clear means normal; resets normal.
// (R2) Power bit 6 set adds a status byte before conversion data.
// (R3) Power bit 5 set appends a check code to transfers.
// (R4) Power bit 4 enables the serial timeout reset; off after reset.
// (R5) Power bits 3:0 drive port pins on write; reads return pin levels.
// (R6) Every power register field resets to zero.
// (R7) Source select bit 4 enables the internal reference; off after reset.
// (R8) Source bits 3:2 choose positive reference; supply code 01 after reset.
// (R9) Source bits 1:0 choose negative reference; supply code 01 after reset.
// (R10) Offset word is three bytes from index 07h, signed, resets zero.
// (R11) The offset is subtracted from each raw result before scaling.
// (R12) Gain word is three bytes 0Ah to 0Ch, unsigned, resets 400000h.
// (R13) Corrected result is multiplied by gain word over 400000h.
// (R14) The calibrated result saturates to the signed 24-bit range.
// (R15) The host writes zeros to source select bits 7:5.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "acr_regs.svh"

module acr_top #(
	parameter int  DATA_W         = 24,
	parameter bit  HAS_PORT_PINS  = 1'b1
) (
	// Clock and reset.
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Wishbone classic slave.
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	input  wire logic                    we_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic [7:0]              adr_i,
	input  wire logic [31:0]             dat_i,
	output logic      [31:0]             dat_o,
	output logic                         ack_o,
	// Option and reference controls.
	output acr_pkg::acr_ctrl_t           ctrl_o,
	// Port pins shared with analog inputs.
	input  wire logic [3:0]              port_pin_dir_i,
	input  wire logic [3:0]              port_pin_level_i,
	output logic      [3:0]              port_pin_level_o,
	output logic      [3:0]              port_pin_oe_n_o,
	// Conversion data path.
	input  wire logic                    raw_valid_i,
	input  wire logic [DATA_W-1:0]       raw_i,
	output logic                         cal_valid_o,
	output logic      [DATA_W-1:0]       cal_o
);

	// Maps a word index onto a storage slot; bit 3 flags an unmapped index.
	function automatic logic [3:0] slot_of(input logic [5:0] idx);
		logic [5:0] rel;
		rel = idx - `ACR_IDX_PWR;
		if (idx >= `ACR_IDX_PWR && idx <= `ACR_IDX_GAIN_HI) begin
			slot_of = {1'b0, rel[2:0]};
		end else begin
			slot_of = 4'h8;
		end
	endfunction

	// Saturates a wide signed product back into the output range.
	function automatic logic [DATA_W-1:0] clamp(input logic signed [49:0] v);
		if (v > $signed({{26{1'b0}}, `ACR_OUT_MAX})) begin
			clamp = `ACR_OUT_MAX;
		end else if (v < $signed({{26{1'b1}}, `ACR_OUT_MIN})) begin
			clamp = `ACR_OUT_MIN;
		end else begin
			clamp = v[DATA_W-1:0];
		end
	endfunction

	localparam logic [2:0] SL_PWR  = 3'(`ACR_IDX_PWR - `ACR_IDX_PWR);
	localparam logic [2:0] SL_VSRC = 3'(`ACR_IDX_VSRC - `ACR_IDX_PWR);
	localparam logic [2:0] SL_OL   = 3'(`ACR_IDX_OFS_LO - `ACR_IDX_PWR);
	localparam logic [2:0] SL_OM   = 3'(`ACR_IDX_OFS_MID - `ACR_IDX_PWR);
	localparam logic [2:0] SL_OH   = 3'(`ACR_IDX_OFS_HI - `ACR_IDX_PWR);
	localparam logic [2:0] SL_GL   = 3'(`ACR_IDX_GAIN_LO - `ACR_IDX_PWR);
	localparam logic [2:0] SL_GM   = 3'(`ACR_IDX_GAIN_MID - `ACR_IDX_PWR);
	localparam logic [2:0] SL_GH   = 3'(`ACR_IDX_GAIN_HI - `ACR_IDX_PWR);

	acr_pkg::acr_bus_st_t st_q, st_d;
	logic [7:0]           regs_q [`ACR_NUM_REGS];
	logic [7:0]           regs_d [`ACR_NUM_REGS];
	logic [31:0]          dat_q, dat_d;
	logic                 ack_q, ack_d;
	logic [3:0]           slot;
	logic                 take;
	logic                 wr_en;
	logic [23:0]          offset_word;
	logic [23:0]          gain_word;
	logic [3:0]           pin_rd;

	// A request is taken once; the ack cycle itself never retakes it.
	assign take        = cyc_i && stb_i && (st_q == acr_pkg::ACR_BUS_IDLE);
	assign slot        = slot_of(adr_i[7:2]);
	assign wr_en       = take && we_i && sel_i[0] && !slot[3];
	assign offset_word = {regs_q[SL_OH], regs_q[SL_OM], regs_q[SL_OL]};  // [R10]
	assign gain_word   = {regs_q[SL_GH], regs_q[SL_GM], regs_q[SL_GL]};  // [R12]
	assign pin_rd      = HAS_PORT_PINS ? port_pin_level_i : 4'h0;

	// Bus sequencing, register writes and read data; unmapped reads return zero.
	always_comb begin
		st_d   = st_q;
		ack_d  = 1'b0;
		dat_d  = dat_q;
		regs_d = regs_q;
		case (st_q)
			acr_pkg::ACR_BUS_IDLE: begin
				if (take) begin
					st_d  = acr_pkg::ACR_BUS_ACK;
					ack_d = 1'b1;
					dat_d = 32'h0;
					if (!slot[3]) begin
						dat_d[7:0] = regs_q[slot[2:0]];
					end
					if (slot[2:0] == SL_PWR && !slot[3]) begin
						dat_d[`ACR_PIN_MSB:0] = pin_rd;  // [R5]
					end
					if (wr_en) begin
						regs_d[slot[2:0]] = dat_i[7:0];  // [R1] [R2] [R3] [R4] [R7] [R8] [R9]
					end
				end
			end
			acr_pkg::ACR_BUS_ACK: begin
				st_d = acr_pkg::ACR_BUS_IDLE;
			end
			default: begin
				st_d = acr_pkg::ACR_BUS_IDLE;
			end
		endcase
	end

	// Bus and register state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q          <= acr_pkg::ACR_BUS_IDLE;
			ack_q         <= 1'b0;
			dat_q         <= 32'h0;
			regs_q[SL_PWR]  <= `ACR_RST_PWR;  // [R6]
			regs_q[SL_VSRC] <= `ACR_RST_VSRC;  // [R7] [R8] [R9]
			regs_q[SL_OL]   <= `ACR_RST_OFS;  // [R10]
			regs_q[SL_OM]   <= `ACR_RST_OFS;
			regs_q[SL_OH]   <= `ACR_RST_OFS;
			regs_q[SL_GL]   <= `ACR_RST_GAIN_LO;  // [R12]
			regs_q[SL_GM]   <= `ACR_RST_GAIN_MID;
			regs_q[SL_GH]   <= `ACR_RST_GAIN_HI;
		end else begin
			st_q   <= st_d;
			ack_q  <= ack_d;
			dat_q  <= dat_d;
			regs_q <= regs_d;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	logic [3:0]           pin_out_q, pin_out_d;
	logic [3:0]           pin_oe_n_q, pin_oe_n_d;
	acr_pkg::acr_ctrl_t   ctrl_q, ctrl_d;

	// Controls and pins are registered copies so every output leaves a flop.
	always_comb begin
		ctrl_d.soft_sleep              = regs_d[SL_PWR][`ACR_BIT_SLEEP];  // [R1]
		ctrl_d.header_byte_on          = regs_d[SL_PWR][`ACR_BIT_HEADER];  // [R2]
		ctrl_d.check_code_on           = regs_d[SL_PWR][`ACR_BIT_CHECK];  // [R3]
		ctrl_d.serial_timeout_reset_on = regs_d[SL_PWR][`ACR_BIT_TIMEOUT];  // [R4]
		ctrl_d.internal_vsrc_on        = regs_d[SL_VSRC][`ACR_BIT_VSRC_ON];  // [R7]
		ctrl_d.pos_vsrc_select         = acr_pkg::acr_pos_src_t'(
			regs_d[SL_VSRC][`ACR_POS_MSB:`ACR_POS_LSB]);  // [R8]
		ctrl_d.neg_vsrc_select         = acr_pkg::acr_neg_src_t'(
			regs_d[SL_VSRC][`ACR_NEG_MSB:`ACR_NEG_LSB]);  // [R9]
		pin_out_d  = HAS_PORT_PINS ? regs_d[SL_PWR][`ACR_PIN_MSB:0] : 4'h0;  // [R5]
		pin_oe_n_d = HAS_PORT_PINS ? port_pin_dir_i : 4'hf;
	end

	// Reset state matches the register reset values.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q     <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
			                acr_pkg::ACR_POS_SUPPLY, acr_pkg::ACR_NEG_SUPPLY};
			pin_out_q  <= 4'h0;
			pin_oe_n_q <= 4'hf;
		end else begin
			ctrl_q     <= ctrl_d;
			pin_out_q  <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
		end
	end

	assign ctrl_o           = ctrl_q;
	assign port_pin_level_o = pin_out_q;
	assign port_pin_oe_n_o  = pin_oe_n_q;

	logic signed [24:0]   diff;
	logic signed [49:0]   prod;
	logic signed [49:0]   scaled;
	logic [DATA_W-1:0]    cal_q, cal_d;
	logic                 cal_v_q, cal_v_d;

	// One-cycle correction: offset first, then gain; sleep discards samples.
	always_comb begin
		diff    = $signed({raw_i[23], raw_i}) - $signed({offset_word[23], offset_word});  // [R11]
		prod    = diff * $signed({1'b0, gain_word});  // [R13]
		scaled  = prod >>> `ACR_GAIN_SHIFT;  // [R13]
		cal_v_d = raw_valid_i && !ctrl_q.soft_sleep;  // [R1]
		cal_d   = cal_v_d ? clamp(scaled) : cal_q;  // [R14]
	end

	// Result holds its last value between samples.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cal_q   <= '0;
			cal_v_q <= 1'b0;
		end else begin
			cal_q   <= cal_d;
			cal_v_q <= cal_v_d;
		end
	end

	assign cal_o       = cal_q;
	assign cal_valid_o = cal_v_q;

	// Checks on the bus, the fields and the correction path.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Bus decode checks.
	bus_ack_once_a: assert property (take |=> ack_o ##1 !ack_o)
		else $error("ack not a single cycle after request");
	unmapped_rd_a: assert property (take && !we_i && slot[3] |=> dat_o == 32'h0)
		else $error("unmapped index did not read as zero");
	// A write with lane 0 switched off is acknowledged but must not touch the byte.
	lane_off_a: assert property (take && we_i && !sel_i[0] && slot == {1'b0, SL_PWR} |=>
		regs_q[SL_PWR] == $past(regs_q[SL_PWR]))
		else $error("write without lane 0 changed the register");

	// Field checks look two edges on, though the written byte shows on the controls one edge on.
	sleep_field_a: assert property (wr_en && slot[2:0] == SL_PWR |=> ##1 // [R1]
		ctrl_o.soft_sleep == $past(dat_i[7], 2))
		else $error("sleep control does not follow write");
	header_field_a: assert property (wr_en && slot[2:0] == SL_PWR |=> ##1 // [R2]
		ctrl_o.header_byte_on == $past(dat_i[6], 2))
		else $error("status byte control does not follow write");
	check_field_a: assert property (wr_en && slot[2:0] == SL_PWR |=> ##1 // [R3]
		ctrl_o.check_code_on == $past(dat_i[5], 2))
		else $error("check code control does not follow write");
	timeout_field_a: assert property (wr_en && slot[2:0] == SL_PWR |=> ##1 // [R4]
		ctrl_o.serial_timeout_reset_on == $past(dat_i[4], 2))
		else $error("timeout reset control does not follow write");
	pin_read_a: assert property (take && !we_i && slot == {1'b0, SL_PWR} |=> // [R5]
		dat_o[3:0] == (HAS_PORT_PINS ? $past(port_pin_level_i) : 4'h0))
		else $error("pin levels not returned on read");
	pwr_reset_a: assert property ($past(rst_i) |-> regs_q[SL_PWR] == 8'h00 && // [R6]
		!ctrl_o.soft_sleep && port_pin_level_o == 4'h0)
		else $error("power register not cleared by reset");
	vsrc_on_a: assert property (wr_en && slot[2:0] == SL_VSRC |=> ##1 // [R7]
		ctrl_o.internal_vsrc_on == $past(dat_i[4], 2))
		else $error("internal reference enable wrong");
	vsrc_reset_a: assert property ($past(rst_i) |-> !ctrl_o.internal_vsrc_on && // [R7]
		ctrl_o.neg_vsrc_select == 2'h1)
		else $error("reference enable or negative select reset wrong");
	pos_src_a: assert property ($past(rst_i) |-> ctrl_o.pos_vsrc_select == 2'h1) // [R8]
		else $error("positive reference reset wrong");
	pos_sel_wr_a: assert property (wr_en && slot[2:0] == SL_VSRC |=> ##1 // [R8]
		ctrl_o.pos_vsrc_select == $past(dat_i[3:2], 2))
		else $error("positive reference select wrong");
	neg_src_a: assert property (wr_en && slot[2:0] == SL_VSRC |=> ##1 // [R9]
		ctrl_o.neg_vsrc_select == $past(dat_i[1:0], 2))
		else $error("negative reference select wrong");

	// Calibration word checks; bytes land at once, with no shadow copy.
	ofs_byte_a: assert property (wr_en && slot[2:0] == SL_OM |=> // [R10]
		offset_word[15:8] == $past(dat_i[7:0]))
		else $error("offset middle byte misplaced");
	gain_reset_a: assert property ($past(rst_i) |-> gain_word == 24'h400000) // [R12]
		else $error("gain word reset wrong");
	gain_byte_a: assert property (wr_en && slot[2:0] == SL_GH |=> // [R12]
		gain_word[23:16] == $past(dat_i[7:0]))
		else $error("gain high byte misplaced");

	// Correction path checks on fixed sample values; the sleep check takes any sample.
	unity_pass_a: assert property (raw_valid_i && !ctrl_o.soft_sleep && // [R11]
		gain_word == 24'h400000 && offset_word == 24'h000010 && raw_i == 24'h000030
		|=> cal_valid_o && cal_o == 24'h000020)
		else $error("offset not subtracted");
	double_gain_a: assert property (raw_valid_i && !ctrl_o.soft_sleep && // [R13]
		gain_word == 24'h800000 && offset_word == 24'h0 && raw_i == 24'h000123
		|=> cal_o == 24'h000246)
		else $error("gain scaling wrong");
	clamp_top_a: assert property (raw_valid_i && !ctrl_o.soft_sleep && // [R14]
		raw_i == 24'h7fffff && offset_word[23] && gain_word >= 24'h400000
		|=> cal_o == 24'h7fffff)
		else $error("result wrapped instead of saturating");
	sleep_drop_a: assert property (raw_valid_i && ctrl_o.soft_sleep |=> !cal_valid_o) // [R1]
		else $error("sample passed while sleeping");

	// Main scenarios that the bench is expected to reach.
	cover_write_c: cover property (wr_en ##1 ack_o);
	cover_read_c: cover property (take && !we_i ##1 ack_o);
	cover_sample_c: cover property (raw_valid_i ##1 cal_valid_o);
	cover_clamp_c: cover property (cal_valid_o && cal_o == 24'h7fffff);
	cover_sleep_c: cover property (raw_valid_i && ctrl_o.soft_sleep);

endmodule

/* verif/acr_front_model.sv */
// Purpose: Far side of the block: sample source and resolved port pins.
// Assumes: The bench sequences requests; this model only shapes the wires.
// Notes:   Idle raw data is inverted so a stale word never looks valid.
`timescale 1ns/1ps

module acr_front_model (
	// Sample request from the bench.
	input  wire logic        smp_req_i,
	input  wire logic [23:0] smp_val_i,
	// Pin levels from the outside world and from the block.
	input  wire logic [3:0]  ext_lvl_i,
	input  wire logic [3:0]  drv_lvl_i,
	input  wire logic [3:0]  oe_n_i,
	// Wires into the block.
	output logic             raw_valid_o,
	output logic [23:0]      raw_o,
	output logic [3:0]       pin_o
);
	// A sample is offered for exactly as long as the bench holds the request.
	assign raw_valid_o = smp_req_i;
	assign raw_o       = smp_req_i ? smp_val_i : ~smp_val_i;
	// A pin follows the block only where its enable is low; else the outside level.
	assign pin_o       = (drv_lvl_i & ~oe_n_i) | (ext_lvl_i & oe_n_i);
endmodule

/* verif/adc_config_calibration_regs_tb_top.sv */
// Purpose: Self-checking bench for the calibration register bank.
// Assumes: Classic Wishbone master tasks that wait for ack however long it takes.
// Notes:   Expected values are worked out here, never read from the design.
`timescale 1ns/1ps
`include "acr_regs.svh"

module adc_config_calibration_regs_tb_top;
	logic               clk_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               cyc_i = 1'b0;
	logic               stb_i = 1'b0;
	logic               we_i = 1'b0;
	logic [3:0]         sel_i = 4'h0;
	logic [7:0]         adr_i = 8'h00;
	logic [31:0]        dat_i = 32'h0;
	logic [31:0]        dat_o;
	logic               ack_o;
	acr_pkg::acr_ctrl_t ctrl_o;
	logic [3:0]         dir = 4'h0;
	logic [3:0]         ext = 4'h0;
	logic [3:0]         pin, lvl_o, oe_n;
	logic               smp_req = 1'b0;
	logic [23:0]        smp_val = 24'h0;
	logic               raw_v, cal_v;
	logic [23:0]        raw, cal;
	logic [31:0]        rd;
	int                 error_cnt = 0;
	int                 n_checks = 0;
	int                 cyc_cnt = 0;
	logic [7:0]         rst_tab [8] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
	// The last two vectors reach the unity and doubling checks inside the design.
	logic [23:0]        c_raw [7] = '{24'h000123, 24'h100000, 24'h7fffff, 24'h800010,
		24'hfffffd, 24'h000030, 24'h000123};
	logic [23:0]        c_ofs [7] = '{24'h000000, 24'h000010, 24'hffff00, 24'h000100,
		24'h000000, 24'h000010, 24'h000000};
	logic [23:0]        c_gn [7] = '{24'h400000, 24'h600000, 24'h400000, 24'h7fffff,
		24'h200000, 24'h400000, 24'h800000};

	acr_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.ctrl_o(ctrl_o), .port_pin_dir_i(dir), .port_pin_level_i(pin),
		.port_pin_level_o(lvl_o), .port_pin_oe_n_o(oe_n), .raw_valid_i(raw_v),
		.raw_i(raw), .cal_valid_o(cal_v), .cal_o(cal));
	acr_front_model fm (.smp_req_i(smp_req), .smp_val_i(smp_val), .ext_lvl_i(ext),
		.drv_lvl_i(lvl_o), .oe_n_i(oe_n), .raw_valid_o(raw_v), .raw_o(raw), .pin_o(pin));

	// Free-running 40 MHz clock.
	always #12.5 clk_i = ~clk_i;

	// Ceiling far above the few hundred cycles the tests need, so a hang ends the run.
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t value %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_cal(input logic [23:0] g, input logic [23:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t result %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_ctl(input acr_pkg::acr_ctrl_t g, input logic [8:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t controls %h expected %h", $time, g, e);
		end
	endtask

	// One classic cycle; the request stays put until ack is sampled, then drops a cycle.
	task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
		input logic s, output logic [31:0] q);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h0, d};
		sel_i <= {3'h0, s};
		// Values read at the edge are those sampled there; only the ceiling ends a hang.
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		wb(1'b1, idx, d, 1'b1, rd);
	endtask

	task automatic rdc(input logic [5:0] idx, input logic [7:0] e);
		wb(1'b0, idx, 8'h00, 1'b1, rd);
		chk32(rd, {24'h0, e});
	endtask

	// Offers one sample for one cycle and looks at the answer just after the edge that takes it.
	task automatic send(input logic [23:0] r, input logic [23:0] e, input logic v);
		@(posedge clk_i);
		smp_req <= 1'b1;
		smp_val <= r;
		@(posedge clk_i);
		smp_req <= 1'b0;
		#1;
		chk32(cal_v, v);
		if (v)
			chk_cal(cal, e);
	endtask

	// Reference arithmetic: signed subtract, scale by gain over 2^22, then saturate.
	function automatic logic [23:0] cal_exp(input logic [23:0] r, o, g);
		longint d;
		longint p;
		d = longint'($signed(r)) - longint'($signed(o));
		p = (d * longint'({1'b0, g})) >>> 22;
		if (p > 64'sd8388607)
			p = 64'sd8388607;
		else if (p < -64'sd8388608)
			p = -64'sd8388608;
		return p[23:0];
	endfunction

	// Main sequence.
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk_ctl(ctrl_o, 9'h005);
		for (int i = 0; i < 8; i++)
			rdc(6'(i + 5), rst_tab[i]);
		wr(6'h0d, 8'hff);
		rdc(6'h0d, 8'h00);
		rdc(6'h00, 8'h00);
		dir <= 4'b0011;
		ext <= 4'b0101;
		wr(`ACR_IDX_PWR, 8'h7a);
		chk_ctl(ctrl_o, 9'h0e5);
		chk32(lvl_o, 32'ha);
		chk32(oe_n, 32'h3);
		rdc(`ACR_IDX_PWR, 8'h79);
		wb(1'b1, `ACR_IDX_PWR, 8'h00, 1'b0, rd);
		rdc(`ACR_IDX_PWR, 8'h79);
		for (int i = 0; i < 4; i++) begin
			wr(`ACR_IDX_VSRC, {4'h1, 2'(i), ~2'(i)});
			chk_ctl(ctrl_o, {5'h0f, 2'(i), ~2'(i)});
			rdc(`ACR_IDX_VSRC, {4'h1, 2'(i), ~2'(i)});
		end
		wr(`ACR_IDX_PWR, 8'h00);
		chk_ctl(ctrl_o, 9'h01c);
		for (int k = 0; k < 7; k++) begin
			for (int b = 0; b < 3; b++) begin
				wr(6'(`ACR_IDX_OFS_LO + b), c_ofs[k][8*b +: 8]);
				wr(6'(`ACR_IDX_GAIN_LO + b), c_gn[k][8*b +: 8]);
			end
			send(c_raw[k], cal_exp(c_raw[k], c_ofs[k], c_gn[k]), 1'b1);
		end
		wr(`ACR_IDX_PWR, 8'h80);
		chk32(ctrl_o.soft_sleep, 32'h1);
		send(24'h000400, 24'h0, 1'b0);
		finish_test();
	end
endmodule
